// >>> rtl/etsr_readout.sv
// AHB-Lite readout of banked seventh and eighth event timestamp samples.
//
// Function
// - Returned nanoseconds and seconds copies are those of the unit named by index bit 8.
// - Bit 30 of each nanoseconds register holds the edge, 1 rising and 0 falling.
// - The seventh-sample nanoseconds register returns the capture nanoseconds in bits 29 to 0.
// - The seventh-sample seconds register returns the capture seconds in all 32 bits.
// - The seventh-sample phase register returns a 3-bit slot code in bits 2 to 0.
// - Slot codes: 000 is 0 ns, 001 is 8 ns, 101 is 16 ns, 011 is 24 ns, 100 is 32 ns.
// - The eighth-sample nanoseconds register returns bits 29 to 0 beside its edge.
// - The eighth-sample seconds register returns the capture seconds in all 32 bits.
// - The seventh-sample registers decode at 0x059C, 0x05A0 and 0x05A4.
// - The eighth-sample nanoseconds and seconds registers decode at 0x05A8 and 0x05AC.
// - The eighth-sample phase register decodes at 0x05B0 with the same slot encoding.
module etsr_readout (
    input  wire logic                      clk,
    input  wire logic                      srst,
    input  wire logic                      ce,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic                           hresp,
    output logic [31:0]                    hrdata,
    input  wire logic [31:0]               unit_index_word,
    input  wire etsr_pkg::etsr_capture_type capture,
    output logic                           capture_ready
);

    // ****************************************
    // Storage
    // ****************************************
    // Edge flag and nanoseconds share one 31-bit word per unit and sample.
    // Only the capture engine writes these arrays; the bus can only read them.
    logic [etsr_pkg::NUM_UNITS-1:0][etsr_pkg::NUM_SAMPLES-1:0][30:0] ns_mem_reg;
    logic [etsr_pkg::NUM_UNITS-1:0][etsr_pkg::NUM_SAMPLES-1:0][31:0] sec_mem_reg;
    logic [etsr_pkg::NUM_SAMPLES-1:0][2:0]                          slot_mem_reg;
    logic [31:0]              hrdata_reg;
    logic [31:0]              hrdata_next;
    etsr_pkg::etsr_state_type state_reg;
    etsr_pkg::etsr_state_type state_next;

    logic                     ptr;
    logic [1:0][30:0]         ns_bank;
    logic [1:0][31:0]         sec_bank;
    logic                     accept;
    logic                     rd_accept;
    logic                     hit_s7_ns;
    logic                     hit_s7_sec;
    logic                     hit_s7_ph;
    logic                     hit_s8_ns;
    logic                     hit_s8_sec;
    logic                     hit_s8_ph;
    logic                     cap_go;
    logic                     slot_legal;
    logic [2:0]               slot_clean;
    logic [30:0]              cap_ns_word;

    // ****************************************
    // Bus handshake
    // ****************************************
    // Zero wait states; a low clock enable stretches the data phase.
    // Size and write data are not decoded: every register is a read-only word,
    // so a write completes OKAY and is dropped.
    assign hreadyout     = ce;
    assign hresp         = 1'b0;
    assign hrdata        = hrdata_reg;
    assign capture_ready = ce & ~srst;
    assign accept        = ce & hsel & htrans[1] & hready;
    assign rd_accept     = accept & ~hwrite;

    // ****************************************
    // Address decode and bank selection
    // ****************************************
    // Decode on the whole word address; any other address reads zero.
    // A misaligned address never matches, so it reads zero; a narrow transfer at a register address returns the whole word.
    assign hit_s7_ns  = haddr == etsr_pkg::S7_NS_OFF;
    assign hit_s7_sec = haddr == etsr_pkg::S7_SEC_OFF;
    assign hit_s7_ph  = haddr == etsr_pkg::S7_PHASE_OFF;
    assign hit_s8_ns  = haddr == etsr_pkg::S8_NS_OFF;
    assign hit_s8_sec = haddr == etsr_pkg::S8_SEC_OFF;
    assign hit_s8_ph  = haddr == etsr_pkg::S8_PHASE_OFF;

    // The pointer is sampled with the address phase, so a later change of it
    // does not disturb a read already under way.
    assign ptr      = unit_index_word[etsr_pkg::UNIT_PTR_BIT];
    assign ns_bank  = ns_mem_reg[ptr];
    assign sec_bank = sec_mem_reg[ptr];

    // Reserved bits are filled with zero by the zero extension.
    // A capture in the same cycle as the address phase is seen by the next read only.
    assign hrdata_next =
        ({32{hit_s7_ns}}  & {1'b0, ns_bank[etsr_pkg::SAMPLE_7TH]})    |
        ({32{hit_s7_sec}} & sec_bank[etsr_pkg::SAMPLE_7TH])           |
        ({32{hit_s7_ph}}  & {29'h0, slot_mem_reg[etsr_pkg::SAMPLE_7TH]}) |
        ({32{hit_s8_ns}}  & {1'b0, ns_bank[etsr_pkg::SAMPLE_8TH]})    |
        ({32{hit_s8_sec}} & sec_bank[etsr_pkg::SAMPLE_8TH])           |
        ({32{hit_s8_ph}}  & {29'h0, slot_mem_reg[etsr_pkg::SAMPLE_8TH]});

    // ****************************************
    // Capture path
    // ****************************************
    // Codes outside the five legal slots are stored as the 0 ns slot, so
    // software never sees an undefined phase code.
    assign slot_legal = (capture.slot_code == etsr_pkg::SLOT_0NS)  |
                        (capture.slot_code == etsr_pkg::SLOT_8NS)  |
                        (capture.slot_code == etsr_pkg::SLOT_16NS) |
                        (capture.slot_code == etsr_pkg::SLOT_24NS) |
                        (capture.slot_code == etsr_pkg::SLOT_32NS);
    assign slot_clean  = slot_legal ? capture.slot_code : etsr_pkg::SLOT_0NS;
    assign cap_go      = ce & capture.valid;
    assign cap_ns_word = {capture.rising, capture.nanosec};

    // Bus writes never reach this storage; only the capture engine fills it.
    generate
        for (genvar u = 0; u < etsr_pkg::NUM_UNITS; u++) begin : g_unit
            always_ff @(posedge clk) begin
                if (srst) begin
                    ns_mem_reg[u]  <= '0;
                    sec_mem_reg[u] <= '0;
                end else if (cap_go && capture.unit == 1'(u)) begin
                    ns_mem_reg[u][capture.sample]  <= cap_ns_word;
                    sec_mem_reg[u][capture.sample] <= capture.whole_sec;
                end
            end
        end
    endgenerate

    // The phase word is not banked, so the last capture of a sample wins.
    always_ff @(posedge clk) begin
        if (srst) begin
            slot_mem_reg <= '0;
        end else if (cap_go) begin
            slot_mem_reg[capture.sample] <= slot_clean;
        end
    end

    // ****************************************
    // Transfer state
    // ****************************************
    // Idle waits for an address phase; data marks the cycle of its answer.
    always_comb begin
        case (state_reg)
            etsr_pkg::ST_IDLE: state_next = accept ? etsr_pkg::ST_DATA : etsr_pkg::ST_IDLE;
            etsr_pkg::ST_DATA: state_next = accept ? etsr_pkg::ST_DATA : etsr_pkg::ST_IDLE;
            default:           state_next = etsr_pkg::ST_IDLE;
        endcase
    end

    // Read data is loaded at the address-phase edge and held until the next
    // read, which keeps hrdata glitch-free through a stretched data phase.
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg  <= etsr_pkg::ST_IDLE;
            hrdata_reg <= etsr_pkg::UNMAPPED_VAL;
        end else if (ce) begin
            state_reg <= state_next;
            if (rd_accept) begin
                hrdata_reg <= hrdata_next;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    // A seventh seconds read returns the copy of the unit the pointer named.
    AST_UNIT_SELECT: assert property (@(posedge clk) disable iff (srst)
        rd_accept && hit_s7_sec |=> hrdata == $past(sec_mem_reg[ptr][0]))
        else $error("seventh seconds read did not follow the unit pointer");

    // The edge of every capture lands in bit 30 of its nanoseconds word.
    AST_EDGE_FLAG: assert property (@(posedge clk) disable iff (srst)
        cap_go |=> ns_mem_reg[$past(capture.unit)][$past(capture.sample)][etsr_pkg::EDGE_BIT]
                   == $past(capture.rising))
        else $error("captured edge flag not stored in bit 30");

    // The seventh nanoseconds read follows the pointer, edge flag included.
    AST_S7_NS: assert property (@(posedge clk) disable iff (srst)
        rd_accept && hit_s7_ns |=>
            hrdata == {1'b0, $past(ns_mem_reg[ptr][0])})
        else $error("seventh nanoseconds read returned a wrong value");

    // Seventh-sample seconds are stored in the captured unit's copy.
    AST_S7_SEC: assert property (@(posedge clk) disable iff (srst)
        cap_go && capture.sample == etsr_pkg::SAMPLE_7TH |=>
            sec_mem_reg[$past(capture.unit)][0] == $past(capture.whole_sec))
        else $error("seventh seconds not stored from capture");

    // Both phase words keep their reserved upper bits at zero.
    AST_PHASE_RESERVED: assert property (@(posedge clk) disable iff (srst)
        rd_accept && (hit_s7_ph || hit_s8_ph) |=> hrdata[31:3] == 29'h0)
        else $error("phase register reserved bits not zero");

    // No undefined slot code is ever held, so software never has to filter one.
    AST_SLOT_LEGAL: assert property (@(posedge clk) disable iff (srst)
        slot_mem_reg[0] != 3'h2 && slot_mem_reg[0][2:1] != 2'b11 &&
        slot_mem_reg[1] != 3'h2 && slot_mem_reg[1][2:1] != 2'b11)
        else $error("undefined slot code stored");

    // Eighth-sample nanoseconds are stored in the captured unit's copy.
    AST_S8_NS: assert property (@(posedge clk) disable iff (srst)
        cap_go && capture.sample == etsr_pkg::SAMPLE_8TH |=>
            ns_mem_reg[$past(capture.unit)][1][29:0] == $past(capture.nanosec))
        else $error("eighth nanoseconds not stored from capture");

    // Eighth-sample seconds are stored in the captured unit's copy.
    AST_S8_SEC: assert property (@(posedge clk) disable iff (srst)
        cap_go && capture.sample == etsr_pkg::SAMPLE_8TH |=>
            sec_mem_reg[$past(capture.unit)][1] == $past(capture.whole_sec))
        else $error("eighth seconds not stored from capture");

    // The eighth phase read returns its unbanked code.
    AST_S8_PHASE: assert property (@(posedge clk) disable iff (srst)
        rd_accept && haddr == etsr_pkg::S8_PHASE_OFF |=>
            hrdata == {29'h0, $past(slot_mem_reg[1])})
        else $error("eighth phase read returned a wrong value");

    // An address outside the six words reads as zero.
    AST_UNMAPPED: assert property (@(posedge clk) disable iff (srst)
        rd_accept && !(hit_s7_ns || hit_s7_sec || hit_s7_ph || hit_s8_ns ||
                       hit_s8_sec || hit_s8_ph) |=> hrdata == 32'h0)
        else $error("unmapped read did not return zero");

    // Bit 31 of both nanoseconds words reads zero.
    AST_NS_RESERVED: assert property (@(posedge clk) disable iff (srst)
        rd_accept && (hit_s7_ns || hit_s8_ns) |=> !hrdata[31])
        else $error("nanoseconds register bit 31 not zero");

    // A bus write leaves all sample storage untouched.
    AST_WRITE_NO_EFFECT: assert property (@(posedge clk) disable iff (srst)
        accept && hwrite && !cap_go |=>
            $stable(ns_mem_reg) && $stable(sec_mem_reg) && $stable(slot_mem_reg))
        else $error("bus write changed sample storage");

    // A capture into one unit must leave the other unit's copies alone.
    AST_OTHER_UNIT_KEPT: assert property (@(posedge clk) disable iff (srst)
        cap_go |=> ns_mem_reg[~$past(capture.unit)] == $past(ns_mem_reg[~capture.unit]) &&
                   sec_mem_reg[~$past(capture.unit)] == $past(sec_mem_reg[~capture.unit]))
        else $error("capture disturbed the other unit's samples");

    // The stored seventh nanoseconds follow the capture word.
    AST_S7_NS_STORE: assert property (@(posedge clk) disable iff (srst)
        cap_go && capture.sample == etsr_pkg::SAMPLE_7TH |=>
            ns_mem_reg[$past(capture.unit)][0][29:0] == $past(capture.nanosec))
        else $error("seventh nanoseconds not stored from capture");

    // The seventh phase read returns its unbanked code.
    AST_S7_PHASE: assert property (@(posedge clk) disable iff (srst)
        rd_accept && hit_s7_ph |=> hrdata == {29'h0, $past(slot_mem_reg[0])})
        else $error("seventh phase read returned a wrong value");

    // Legal slot codes are kept exactly as captured.
    AST_SLOT_KEEP: assert property (@(posedge clk) disable iff (srst)
        cap_go && capture.slot_code inside {3'h0, 3'h1, 3'h3, 3'h4, 3'h5} |=>
            slot_mem_reg[$past(capture.sample)] == $past(capture.slot_code))
        else $error("legal slot code not kept");

    // Undefined slot codes are folded to the 0 ns slot.
    AST_SLOT_FOLD: assert property (@(posedge clk) disable iff (srst)
        cap_go && capture.slot_code inside {3'h2, 3'h6, 3'h7} |=>
            slot_mem_reg[$past(capture.sample)] == 3'h0)
        else $error("undefined slot code not folded to zero");

    // The eighth nanoseconds read follows the pointer and keeps bit 31 clear.
    AST_S8_NS_READ: assert property (@(posedge clk) disable iff (srst)
        rd_accept && hit_s8_ns |=> hrdata == {1'b0, $past(ns_mem_reg[ptr][1])})
        else $error("eighth nanoseconds read returned a wrong value");

    // The eighth seconds read follows the pointer.
    AST_S8_SEC_READ: assert property (@(posedge clk) disable iff (srst)
        rd_accept && hit_s8_sec |=> hrdata == $past(sec_mem_reg[ptr][1]))
        else $error("eighth seconds read returned a wrong value");

    // A low clock enable freezes storage, read data and transfer state.
    AST_FROZEN: assert property (@(posedge clk) disable iff (srst)
        !ce |=> $stable(ns_mem_reg) && $stable(sec_mem_reg) && $stable(slot_mem_reg) &&
                $stable(hrdata) && $stable(state_reg))
        else $error("state changed while the clock enable was low");

    // Reset clears every copy and the read data, whatever the clock enable.
    AST_RESET_ZERO: assert property (@(posedge clk)
        srst |=> ns_mem_reg == '0 && sec_mem_reg == '0 && slot_mem_reg == '0 &&
                 hrdata == 32'h0)
        else $error("reset did not clear the sample storage");

    // Covers for a read of each sample, the unit 1 bank, a write and back-to-back transfers.
    COV_READ_S7: cover property (@(posedge clk) disable iff (srst)
        rd_accept && hit_s7_ns ##1 ce);
    COV_READ_UNIT1: cover property (@(posedge clk) disable iff (srst)
        rd_accept && hit_s8_sec && ptr ##1 ce);
    COV_CAPTURE_THEN_READ: cover property (@(posedge clk) disable iff (srst)
        cap_go ##[1:4] rd_accept && hit_s8_ph);
    COV_WRITE: cover property (@(posedge clk) disable iff (srst)
        accept && hwrite ##1 ce);
    COV_BACK_TO_BACK: cover property (@(posedge clk) disable iff (srst)
        state_reg == etsr_pkg::ST_DATA && accept);

endmodule : etsr_readout

// >>> shared/etsr_pkg.sv
// Package of offsets, field layouts, codes and types for the timestamp sample readout block.
package etsr_pkg;

    // ****************************************
    // Register offsets, byte addresses
    // ****************************************
    localparam logic [31:0] S7_NS_OFF    = 32'h0000059C;
    localparam logic [31:0] S7_SEC_OFF   = 32'h000005A0;
    localparam logic [31:0] S7_PHASE_OFF = 32'h000005A4;
    localparam logic [31:0] S8_NS_OFF    = 32'h000005A8;
    localparam logic [31:0] S8_SEC_OFF   = 32'h000005AC;
    localparam logic [31:0] S8_PHASE_OFF = 32'h000005B0;

    // ****************************************
    // Field layout and reset values
    // ****************************************
    localparam int          UNIT_PTR_BIT = 8;
    localparam int          NUM_UNITS    = 2;
    localparam int          NUM_SAMPLES  = 2;
    localparam int          EDGE_BIT     = 30;
    localparam int          NS_W         = 30;
    localparam int          SEC_W        = 32;
    localparam int          SLOT_W       = 3;
    localparam logic [30:0] NS_RESET     = 31'h00000000;
    localparam logic [31:0] SEC_RESET    = 32'h00000000;
    localparam logic [2:0]  SLOT_RESET   = 3'h0;
    localparam logic [31:0] UNMAPPED_VAL = 32'h00000000;
    localparam logic        SAMPLE_7TH   = 1'b0;
    localparam logic        SAMPLE_8TH   = 1'b1;

    // ****************************************
    // Sub-cycle slot codes within the 40 ns reference period
    // ****************************************
    localparam logic [2:0] SLOT_0NS  = 3'h0;
    localparam logic [2:0] SLOT_8NS  = 3'h1;
    localparam logic [2:0] SLOT_16NS = 3'h5;
    localparam logic [2:0] SLOT_24NS = 3'h3;
    localparam logic [2:0] SLOT_32NS = 3'h4;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic               valid;
        logic               unit;
        logic               sample;
        logic               rising;
        logic [NS_W-1:0]    nanosec;
        logic [SEC_W-1:0]   whole_sec;
        logic [SLOT_W-1:0]  slot_code;
    } etsr_capture_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DATA = 2'b10
    } etsr_state_type;

endpackage : etsr_pkg

// >>> tb/tb_event_timestamp_sample_readout.sv
// Self-checking testbench for the timestamp sample readout block.
module tb_event_timestamp_sample_readout;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Clock, reset and design ports
    // ****************************************
    logic                        clk;
    logic                        srst;
    logic                        ce;
    logic                        hsel;
    logic [31:0]                 haddr;
    logic [1:0]                  htrans;
    logic                        hwrite;
    logic [31:0]                 hwdata;
    logic                        hreadyout;
    logic                        hresp;
    logic [31:0]                 hrdata;
    logic [31:0]                 unit_index_word;
    etsr_pkg::etsr_capture_type  cap;
    logic                        capture_ready;
    logic [30:0]                 m_ns [2][2];
    logic [31:0]                 m_sec [2][2];
    logic [2:0]                  m_slot [2];
    logic [31:0]                 addrs [7];
    int                          num_errors;
    int                          tests_run;
    int                          cycles;
    int                          seed;

    etsr_readout DUT (
        .clk             (clk),
        .srst            (srst),
        .ce              (ce),
        .hsel            (hsel),
        .haddr           (haddr),
        .htrans          (htrans),
        .hwrite          (hwrite),
        .hsize           (3'h2),
        .hwdata          (hwdata),
        .hready          (hreadyout),
        .hreadyout       (hreadyout),
        .hresp           (hresp),
        .hrdata          (hrdata),
        .unit_index_word (unit_index_word),
        .capture         (cap),
        .capture_ready   (capture_ready)
    );

    // Free-running clock of 100 ns period.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Hang guard: well above the roughly 1200 cycles the run needs.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            end_sim();
        end
    end

    // ****************************************
    // Expectations, bus and capture tasks
    // ****************************************
    // Undefined slot codes are stored as zero, so the model folds them the same way.
    function automatic logic [2:0] fold_slot(input logic [2:0] c);
        return (c == 3'h2 || c > 3'h5) ? 3'h0 : c;
    endfunction : fold_slot

    function automatic logic [31:0] exp_rd(input logic [31:0] a, input logic u);
        case (a)
            etsr_pkg::S7_NS_OFF:    return {1'b0, m_ns[u][0]};
            etsr_pkg::S7_SEC_OFF:   return m_sec[u][0];
            etsr_pkg::S7_PHASE_OFF: return {29'h0, m_slot[0]};
            etsr_pkg::S8_NS_OFF:    return {1'b0, m_ns[u][1]};
            etsr_pkg::S8_SEC_OFF:   return m_sec[u][1];
            etsr_pkg::S8_PHASE_OFF: return {29'h0, m_slot[1]};
            default:                return 32'h00000000;
        endcase
    endfunction : exp_rd

    // One single AHB-Lite transfer; the wait ends only on hready or the hang guard.
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer

    // One status compare; the caller's line names the rule it checks.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run = tests_run + 1;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            num_errors = num_errors + 1;
        end
    endtask : chk

    task automatic rd_chk(input logic [31:0] a);
        logic [31:0] q;
        xfer(1'b0, a, 32'h00000000, q);
        tests_run = tests_run + 1;
        if (q !== exp_rd(a, unit_index_word[etsr_pkg::UNIT_PTR_BIT])) begin
            $display("BAD reg %h exp %h got %h", a,
                     exp_rd(a, unit_index_word[etsr_pkg::UNIT_PTR_BIT]), q);
            num_errors = num_errors + 1;
        end
        chk("hresp", 32'h00000000, 32'(hresp));
        chk("capture_ready", 32'h00000001, 32'(capture_ready));
    endtask : rd_chk

    // A one-cycle capture pulse; the model follows only when the block is enabled.
    task automatic capt(input logic u, input logic s, input logic r, input logic [29:0] n,
                        input logic [31:0] sc, input logic [2:0] c);
        @(posedge clk);
        cap <= '{valid: 1'b1, unit: u, sample: s, rising: r, nanosec: n,
                 whole_sec: sc, slot_code: c};
        @(posedge clk);
        cap.valid <= 1'b0;
        if (ce) begin
            m_ns[u][s]  = {r, n};
            m_sec[u][s] = sc;
            m_slot[s]   = fold_slot(c);
        end
    endtask : capt

    task automatic rd_all();
        for (int i = 0; i < 7; i++) begin
            rd_chk(addrs[i]);
        end
    endtask : rd_all

    task automatic end_sim();
        $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] q;
        addrs = '{etsr_pkg::S7_NS_OFF, etsr_pkg::S7_SEC_OFF, etsr_pkg::S7_PHASE_OFF,
                  etsr_pkg::S8_NS_OFF, etsr_pkg::S8_SEC_OFF, etsr_pkg::S8_PHASE_OFF,
                  32'h000005B4};
        seed = 32'hD6AE;
        num_errors = 0;
        tests_run = 0;
        cycles = 0;
        m_ns = '{default: 31'h0};
        m_sec = '{default: 32'h0};
        m_slot = '{default: 3'h0};
        {srst, ce, hsel, haddr, htrans, hwrite, hwdata, unit_index_word} = '0;
        srst = 1'b1;
        cap = '0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        ce <= 1'b1;
        // Reset values on both unit banks, plus one unmapped word.
        rd_all();
        unit_index_word <= 32'h00000100;
        rd_all();
        // Every slot code once, even codes on the seventh sample and odd on the eighth, reserved ones included.
        for (int c = 0; c < 8; c++) begin
            capt(1'b0, c[0], c[1], 30'h3FFFFFFF, 32'hFFFFFFFF, 3'(c));
            rd_chk(c[0] ? etsr_pkg::S8_PHASE_OFF : etsr_pkg::S7_PHASE_OFF);
        end
        // A capture while the block is frozen must leave storage untouched.
        ce <= 1'b0;
        capt(1'b1, 1'b0, 1'b1, 30'h15555555, 32'hA5A5A5A5, 3'h4);
        chk("frozen_capture_ready", 32'h00000000, 32'(capture_ready));
        chk("frozen_hreadyout", 32'h00000000, 32'(hreadyout));
        ce <= 1'b1;
        rd_all();
        // Random captures, pointer values and ignored writes.
        for (int i = 0; i < 40; i++) begin
            capt(1'($random(seed)), 1'($random(seed)), 1'($random(seed)),
                 30'($random(seed)), $random(seed), 3'($random(seed)));
            unit_index_word <= $random(seed);
            xfer(1'b1, addrs[i % 7], $random(seed), q);
            rd_all();
        end
        // A second reset in mid-run must clear both banks and the read data.
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        chk("reset_hrdata", 32'h00000000, hrdata);
        chk("reset_capture_ready", 32'h00000000, 32'(capture_ready));
        srst <= 1'b0;
        m_ns = '{default: 31'h0};
        m_sec = '{default: 32'h0};
        m_slot = '{default: 3'h0};
        rd_all();
        unit_index_word <= unit_index_word ^ 32'h00000100;
        rd_all();
        end_sim();
    end

endmodule : tb_event_timestamp_sample_readout
